// *** src/dbad_pkg.sv ***
// Functional notes
// - select monitor rom for memory addresses F800..FFFF
// - select user rom for memory addresses F400..F7FF
// - select monitor scratch ram for memory addresses F300..F3FF
// - below F000 and below io F0 is user; F000..F2FF reserved
// - user ram is one 4k window, upper nibble 0..E
// - window position follows the board switches in 4k steps
// - keyboard/display selected at io ports F0 and F1
// - serial typewriter usart selected at io ports F4 and F5
// - system control port selected at io ports F8..FB
// - user parallel port at four io ports, upper nibble 0..E
// - substitution serves target low 4k from board ram
// - substitution by panel key; ram then executable and writable
// - substitution lamp lit exactly while substitution is on
// - hold lamp lit while cpu is in bus hold
// - top interrupt masked by command and while monitor runs
// - mask lamp lit while monitor runs or mask command holds
// - other interrupts pass from target unmodified
// - substitution key maps board ram over the low 4k
package dbad_pkg;
  // ----------------------------------------------------------
  // memory map
  // ----------------------------------------------------------
  localparam logic [15:0] MON_ROM_BASE  = 16'hF800;
  localparam logic [15:0] USER_ROM_BASE = 16'hF400;
  localparam logic [15:0] USER_ROM_LAST = 16'hF7FF;
  localparam logic [15:0] MON_RAM_BASE  = 16'hF300;
  localparam logic [15:0] MON_RAM_LAST  = 16'hF3FF;
  localparam logic [15:0] SYS_MEM_BASE  = 16'hF000;
  localparam logic [15:0] SUBST_LAST    = 16'h0FFF;
  localparam logic [3:0]  NIB_OFF       = 4'hF;
  // ----------------------------------------------------------
  // io map
  // ----------------------------------------------------------
  localparam logic [7:0] SYS_IO_BASE = 8'hF0;
  localparam logic [7:0] KBD_DATA    = 8'hF0;
  localparam logic [7:0] KBD_CMD     = 8'hF1;
  localparam logic [7:0] USART_DATA  = 8'hF4;
  localparam logic [7:0] USART_CMD   = 8'hF5;
  localparam logic [7:0] SYSCTL_BASE = 8'hF8;
  localparam logic [7:0] SYSCTL_LAST = 8'hFB;
  localparam logic [3:0] PPI_LOW_LAST = 4'h3;
  // ----------------------------------------------------------
  // register port
  // ----------------------------------------------------------
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_SWITCH = 2'h2;
  localparam int CTRL_TRAP_MASK   = 0;
  localparam int CTRL_SUBST_OFF   = 1;
  localparam int STAT_SUBST       = 0;
  localparam int STAT_HOLD        = 1;
  localparam int STAT_MONITOR     = 2;
  localparam int STAT_RESERVED    = 3;
  localparam logic RST_TRAP_MASK  = 1'b0;
  localparam logic RST_MONITOR    = 1'b1;
  localparam logic RST_SUBST      = 1'b0;
endpackage

// *** src/dbad_decoder.sv ***
`timescale 1ns/1ps
module dbad_decoder
  import dbad_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // cpu bus, same clock
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_io_cycle,
  input  wire logic        cpu_bus_cycle,
  input  wire logic        cpu_fetch,
  input  wire logic        cpu_hold_ack,
  // front panel and board switches
  input  wire logic        substitute_memory_key,
  input  wire logic [3:0]  ram_window_switch,
  input  wire logic [3:0]  ppi_window_switch,
  // target interrupt pins
  input  wire logic        target_trap,
  input  wire logic [3:0]  target_irq,
  // register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // memory selects
  output logic             sel_monitor_rom,
  output logic             sel_user_rom,
  output logic             sel_monitor_ram,
  output logic             sel_user_ram,
  output logic      [11:0] user_ram_offset,
  output logic             sel_target_mem,
  // io selects
  output logic             sel_kbd_display,
  output logic             sel_usart,
  output logic             sel_sysctl,
  output logic             sel_user_ppi,
  output logic             sel_target_io,
  // cpu interrupt inputs
  output logic             cpu_trap,
  output logic      [3:0]  cpu_irq,
  // lamps
  output logic             substitute_lamp,
  output logic             hold_lamp,
  output logic             priority_interrupt_mask_lamp
);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic nib_hit(input logic [3:0] a,
                                   input logic [3:0] sw);
    nib_hit = (sw != NIB_OFF) && (a == sw);
  endfunction

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [13:0] pin_meta;
  logic [13:0] pin_sync;
  logic        key_prev;

  always_ff @(posedge core_clk) begin
    pin_meta <= {substitute_memory_key, target_trap, target_irq,
                 ppi_window_switch, ram_window_switch};
    pin_sync <= pin_meta;
  end

  logic [3:0] ram_sw;
  logic [3:0] ppi_sw;
  logic [3:0] irq_s;
  logic       trap_s;
  logic       key_s;
  assign ram_sw = pin_sync[3:0];
  assign ppi_sw = pin_sync[7:4];
  assign irq_s  = pin_sync[11:8];
  assign trap_s = pin_sync[12] ? 1'b1 : 1'b0;
  assign key_s  = pin_sync[13];

  // ----------------------------------------------------------
  // memory decode
  // ----------------------------------------------------------
  logic [15:0] port16;
  logic        mem;
  logic        io;
  logic        sys_mem;
  logic        hit_mon_rom;
  logic        hit_user_rom;
  logic        hit_mon_ram;
  logic        mem_reserved;
  logic        low_area;
  logic        hit_user_ram;
  logic        hit_target_mem;
  logic        subst_on;

  assign mem     = cpu_bus_cycle && !cpu_io_cycle;
  assign io      = cpu_bus_cycle && cpu_io_cycle;
  assign sys_mem = mem && (cpu_addr >= SYS_MEM_BASE);
  assign hit_mon_rom  = mem && (cpu_addr >= MON_ROM_BASE);
  assign hit_user_rom = mem &&
    in_range(cpu_addr, USER_ROM_BASE, USER_ROM_LAST);
  assign hit_mon_ram  = mem &&
    in_range(cpu_addr, MON_RAM_BASE, MON_RAM_LAST);
  assign mem_reserved = sys_mem && (cpu_addr < MON_RAM_BASE);
  assign low_area = cpu_addr <= SUBST_LAST;
  // substitution takes the low 4k over the switch window
  assign hit_user_ram = mem && !sys_mem &&
    (subst_on ? low_area
              : nib_hit(cpu_addr[15:12], ram_sw));
  assign hit_target_mem = mem && !sys_mem && !hit_user_ram;

  // ----------------------------------------------------------
  // io decode
  // ----------------------------------------------------------
  logic [7:0] port;
  logic       sys_io;
  logic       hit_kbd;
  logic       hit_usart;
  logic       hit_sysctl;
  logic       hit_ppi;
  logic       io_reserved;
  logic       hit_target_io;

  assign port   = cpu_addr[7:0];
  assign port16 = {8'h00, port};
  assign sys_io = io && (port >= SYS_IO_BASE);
  assign hit_kbd = io && in_range(port16, {8'h00, KBD_DATA},
                                  {8'h00, KBD_CMD});
  assign hit_usart = io && in_range(port16, {8'h00, USART_DATA},
                                    {8'h00, USART_CMD});
  assign hit_sysctl = io && in_range(port16, {8'h00, SYSCTL_BASE},
                                     {8'h00, SYSCTL_LAST});
  assign hit_ppi = io && !sys_io && nib_hit(port[7:4], ppi_sw) &&
                   (port[3:0] <= PPI_LOW_LAST);
  // other system ports are flagged, never selected
  assign io_reserved = sys_io && !hit_kbd && !hit_usart &&
                       !hit_sysctl;
  assign hit_target_io = io && !sys_io && !hit_ppi;

  // ----------------------------------------------------------
  // select outputs, one cycle after the address
  // ----------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sel_monitor_rom <= 1'b0;
      sel_user_rom    <= 1'b0;
      sel_monitor_ram <= 1'b0;
      sel_user_ram    <= 1'b0;
      user_ram_offset <= 12'h000;
      sel_target_mem  <= 1'b0;
      sel_kbd_display <= 1'b0;
      sel_usart       <= 1'b0;
      sel_sysctl      <= 1'b0;
      sel_user_ppi    <= 1'b0;
      sel_target_io   <= 1'b0;
    end else begin
      sel_monitor_rom <= hit_mon_rom;
      sel_user_rom    <= hit_user_rom;
      sel_monitor_ram <= hit_mon_ram;
      sel_user_ram    <= hit_user_ram;
      user_ram_offset <= cpu_addr[11:0];
      sel_target_mem  <= hit_target_mem;
      sel_kbd_display <= hit_kbd;
      sel_usart       <= hit_usart;
      sel_sysctl      <= hit_sysctl;
      sel_user_ppi    <= hit_ppi;
      sel_target_io   <= hit_target_io;
    end
  end

  // ----------------------------------------------------------
  // substitution, monitor tracking, masking
  // ----------------------------------------------------------
  logic key_press;
  logic subst_clear;
  logic trap_mask_cmd;
  logic monitor_active;
  logic mask_active;
  logic reserved_hit;
  logic ctrl_wr;
  logic stat_wr;

  assign subst_on    = substitute_lamp;
  assign key_press   = key_s && !key_prev;
  assign ctrl_wr     = reg_write && (reg_addr == REG_CTRL);
  assign stat_wr     = reg_write && (reg_addr == REG_STATUS);
  assign subst_clear = ctrl_wr && reg_wdata[CTRL_SUBST_OFF];
  assign mask_active = monitor_active || trap_mask_cmd;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      key_prev        <= 1'b0;
      substitute_lamp <= RST_SUBST;
    end else begin
      key_prev <= key_s;
      // a key press in the clearing cycle still sets the flag
      if (key_press)
        substitute_lamp <= 1'b1;
      else if (subst_clear)
        substitute_lamp <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      monitor_active <= RST_MONITOR;
    end else if (mem && cpu_fetch) begin
      monitor_active <= hit_mon_rom;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      trap_mask_cmd <= RST_TRAP_MASK;
    end else if (ctrl_wr) begin
      trap_mask_cmd <= reg_wdata[CTRL_TRAP_MASK];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reserved_hit <= 1'b0;
    end else if (mem_reserved || io_reserved) begin
      reserved_hit <= 1'b1;
    end else if (stat_wr && reg_wdata[STAT_RESERVED]) begin
      reserved_hit <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_lamp                    <= 1'b0;
      priority_interrupt_mask_lamp <= 1'b0;
      cpu_trap                     <= 1'b0;
      cpu_irq                      <= 4'h0;
    end else begin
      hold_lamp                    <= cpu_hold_ack;
      priority_interrupt_mask_lamp <= mask_active;
      cpu_trap                     <= trap_s && !mask_active;
      cpu_irq                      <= irq_s;
    end
  end

  // ----------------------------------------------------------
  // register read
  // ----------------------------------------------------------
  logic [7:0] rd_mux;
  assign rd_mux =
    (reg_addr == REG_CTRL)   ? {7'h00, trap_mask_cmd} :
    (reg_addr == REG_STATUS) ? {4'h0, reserved_hit, monitor_active,
                                hold_lamp, substitute_lamp} :
    (reg_addr == REG_SWITCH) ? {ppi_sw, ram_sw} : 8'h00;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_mon_rom_select: assert property (
    mem && cpu_addr >= 16'hF800 |=> sel_monitor_rom && !sel_target_mem)
    else $error("monitor rom not selected");
  a_user_rom_select: assert property (
    mem && cpu_addr[15:10] == 6'b111101 |=> sel_user_rom)
    else $error("user rom not selected");
  a_mon_ram_select: assert property (
    mem && cpu_addr[15:8] == 8'hF3 |=> sel_monitor_ram)
    else $error("monitor ram not selected");
  a_reserved_gap: assert property (
    mem && cpu_addr >= 16'hF000 && cpu_addr < 16'hF300
    |=> !sel_target_mem && !sel_user_ram && reserved_hit)
    else $error("reserved memory gap decoded");
  a_ram_window: assert property (
    mem && !subst_on && ram_sw != 4'hF && cpu_addr[15:12] == ram_sw
    |=> sel_user_ram && user_ram_offset == $past(cpu_addr[11:0]))
    else $error("switch window ram not selected");
  a_kbd_usart: assert property (
    io && port[7:1] == 7'h78 |=> sel_kbd_display && !sel_usart)
    else $error("keyboard port not selected");
  a_usart_select: assert property (
    io && port[7:1] == 7'h7A |=> sel_usart && !sel_kbd_display)
    else $error("usart port not selected");
  a_sysctl_select: assert property (
    io && port[7:2] == 6'h3E |=> sel_sysctl && !sel_target_io)
    else $error("system control port not selected");
  a_ppi_select: assert property (
    io && ppi_sw != 4'hF && port[7:4] == ppi_sw && port[3:2] == 2'b00
    |=> sel_user_ppi && !sel_target_io)
    else $error("user parallel port not selected");
  a_subst_low_area: assert property (
    mem && subst_on && cpu_addr < 16'h1000
    |=> sel_user_ram && !sel_target_mem)
    else $error("substituted area not served by board ram");
  a_subst_key_sets: assert property (
    key_s && !key_prev |=> substitute_lamp [*2])
    else $error("key press did not enable substitution");
  a_hold_lamp: assert property (
    cpu_hold_ack [*2] |-> ##1 hold_lamp)
    else $error("hold lamp not lit");
  a_trap_masked: assert property (
    mask_active |=> !cpu_trap && priority_interrupt_mask_lamp)
    else $error("trap passed while masked");
  a_irq_pass: assert property (
    1'b1 |=> cpu_irq == $past(irq_s))
    else $error("interrupt not passed through");
  a_one_select: assert property (
    $onehot0({sel_monitor_rom, sel_user_rom, sel_monitor_ram,
              sel_user_ram, sel_target_mem, sel_kbd_display, sel_usart,
              sel_sysctl, sel_user_ppi, sel_target_io}))
    else $error("more than one resource selected");
  a_reserved_io: assert property (
    io && (port[7:1] == 7'h79 || port[7:1] == 7'h7B || port[7:2] == 6'h3F)
    |=> !sel_target_io && !sel_user_ppi && reserved_hit)
    else $error("reserved io port decoded");
  a_trap_pass: assert property (
    !mask_active |=> cpu_trap == $past(trap_s))
    else $error("trap not passed while unmasked");
  a_subst_clear: assert property (
    subst_clear && !key_press |=> !substitute_lamp)
    else $error("substitution lamp lit after clear");

  c_subst_fetch: cover property (
    key_press ##[1:20] (mem && cpu_fetch && low_area));
  c_monitor_to_user: cover property (
    monitor_active ##[1:50] !monitor_active);
  c_reserved_io: cover property (io_reserved);
  c_ppi_access: cover property (hit_ppi ##1 sel_user_ppi);
  c_subst_clear: cover property (subst_clear ##1 !substitute_lamp);

endmodule

// *** bench/dbad_bus_model.sv ***
`timescale 1ns/1ps
module dbad_bus_model
  import dbad_pkg::*;
(
  // clock
  input  wire logic        core_clk,
  // cpu bus toward the decoder
  output logic      [15:0] cpu_addr,
  output logic             cpu_io_cycle,
  output logic             cpu_bus_cycle,
  output logic             cpu_fetch
);
  initial begin
    cpu_addr      = 16'h0000;
    cpu_io_cycle  = 1'b0;
    cpu_bus_cycle = 1'b0;
    cpu_fetch     = 1'b0;
  end

  // ----------------------------------------------------------
  // one bus cycle; reserved places only when a test commands it
  // ----------------------------------------------------------
  task automatic access(input logic io, input logic [15:0] a,
                        input logic f);
    @(posedge core_clk);
    cpu_addr      <= a;
    cpu_io_cycle  <= io;
    cpu_fetch     <= f;
    cpu_bus_cycle <= 1'b1;
    @(posedge core_clk);
    cpu_bus_cycle <= 1'b0;
    cpu_fetch     <= 1'b0;
    // released bus no longer shows the last address
    cpu_addr      <= ~a;
  endtask
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb
  import dbad_pkg::*;
;
  localparam logic [9:0] S_MROM = 10'h200;
  localparam logic [9:0] S_UROM = 10'h100;
  localparam logic [9:0] S_MRAM = 10'h080;
  localparam logic [9:0] S_URAM = 10'h040;
  localparam logic [9:0] S_TMEM = 10'h020;
  localparam logic [9:0] S_KBD  = 10'h010;
  localparam logic [9:0] S_UART = 10'h008;
  localparam logic [9:0] S_SCTL = 10'h004;
  localparam logic [9:0] S_PPI  = 10'h002;
  localparam logic [9:0] S_TIO  = 10'h001;

  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] cpu_addr;
  logic        cpu_io_cycle;
  logic        cpu_bus_cycle;
  logic        cpu_fetch;
  logic        cpu_hold_ack = 1'b0;
  logic        substitute_memory_key = 1'b0;
  logic [3:0]  ram_window_switch = 4'h2;
  logic [3:0]  ppi_window_switch = 4'h3;
  logic        target_trap = 1'b1;
  logic [3:0]  target_irq = 4'h0;
  logic [1:0]  reg_addr = 2'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [7:0]  reg_rdata;
  logic [9:0]  sels;
  logic [11:0] user_ram_offset;
  logic        s0, s1, s2, s3, s4, s5, s6, s7, s8, s9;
  logic        cpu_trap;
  logic [3:0]  cpu_irq;
  logic        substitute_lamp;
  logic        hold_lamp;
  logic        priority_interrupt_mask_lamp;
  logic [7:0]  rd;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  assign sels = {s0, s1, s2, s3, s4, s5, s6, s7, s8, s9};

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  dbad_bus_model i_cpu (.core_clk(core_clk), .cpu_addr(cpu_addr),
    .cpu_io_cycle(cpu_io_cycle), .cpu_bus_cycle(cpu_bus_cycle),
    .cpu_fetch(cpu_fetch));

  dbad_decoder i_dut (.core_clk(core_clk), .reset(reset),
    .cpu_addr(cpu_addr), .cpu_io_cycle(cpu_io_cycle),
    .cpu_bus_cycle(cpu_bus_cycle), .cpu_fetch(cpu_fetch),
    .cpu_hold_ack(cpu_hold_ack),
    .substitute_memory_key(substitute_memory_key),
    .ram_window_switch(ram_window_switch),
    .ppi_window_switch(ppi_window_switch), .target_trap(target_trap),
    .target_irq(target_irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sel_monitor_rom(s0), .sel_user_rom(s1), .sel_monitor_ram(s2),
    .sel_user_ram(s3), .user_ram_offset(user_ram_offset),
    .sel_target_mem(s4), .sel_kbd_display(s5), .sel_usart(s6),
    .sel_sysctl(s7), .sel_user_ppi(s8), .sel_target_io(s9),
    .cpu_trap(cpu_trap), .cpu_irq(cpu_irq),
    .substitute_lamp(substitute_lamp), .hold_lamp(hold_lamp),
    .priority_interrupt_mask_lamp(priority_interrupt_mask_lamp));

  // ----------------------------------------------------------
  // comparisons and verdict
  // ----------------------------------------------------------
  task automatic tally(input logic ok, input logic [15:0] g,
                       input logic [15:0] e);
    total_checks++;
    if (!ok) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic check_sel(input logic [9:0] g, input logic [9:0] e);
    tally(g === e, {6'h00, g}, {6'h00, e});
  endtask
  task automatic check_reg(input logic [15:0] g, input logic [15:0] e);
    tally(g === e, g, e);
  endtask
  task automatic check_flag(input logic g, input logic e);
    tally(g === e, {15'h0000, g}, {15'h0000, e});
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------
  task automatic bus(input logic io, input logic [15:0] a,
                     input logic [9:0] e);
    i_cpu.access(io, a, 1'b0);
    #1;
    check_sel(sels, e);
  endtask
  task automatic fetch(input logic [15:0] a);
    i_cpu.access(1'b0, a, 1'b1);
    #1;
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_lamp(input logic v);
    int n;
    n = 0;
    while (substitute_lamp !== v && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    #1;
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    settle(2);
    check_flag(priority_interrupt_mask_lamp, 1'b1);
    check_flag(cpu_trap, 1'b0);
    check_flag(substitute_lamp, 1'b0);
    bus(1'b0, 16'hF800, S_MROM);
    bus(1'b0, 16'hFFFF, S_MROM);
    bus(1'b0, 16'hF7FF, S_UROM);
    bus(1'b0, 16'hF400, S_UROM);
    bus(1'b0, 16'hF3FF, S_MRAM);
    bus(1'b0, 16'hF300, S_MRAM);
    bus(1'b0, 16'hF2FF, 10'h000);
    bus(1'b0, 16'hF000, 10'h000);
    bus(1'b0, 16'hEFFF, S_TMEM);
    bus(1'b0, 16'h2000, S_URAM);
    bus(1'b0, 16'h2ABC, S_URAM);
    check_reg({4'h0, user_ram_offset}, 16'h0ABC);
    bus(1'b0, 16'h1FFF, S_TMEM);
    bus(1'b0, 16'h3000, S_TMEM);
    bus(1'b1, 16'hF0F0, S_KBD);
    bus(1'b1, 16'hF1F1, S_KBD);
    bus(1'b1, 16'hF4F4, S_UART);
    bus(1'b1, 16'hF5F5, S_UART);
    bus(1'b1, 16'hF8F8, S_SCTL);
    bus(1'b1, 16'hFBFB, S_SCTL);
    bus(1'b1, 16'hF2F2, 10'h000);
    bus(1'b1, 16'hF7F7, 10'h000);
    bus(1'b1, 16'hFCFC, 10'h000);
    bus(1'b1, 16'hFFFF, 10'h000);
    bus(1'b1, 16'h3030, S_PPI);
    bus(1'b1, 16'h3333, S_PPI);
    bus(1'b1, 16'h3434, S_TIO);
    bus(1'b1, 16'hEFEF, S_TIO);
    @(posedge core_clk);
    ram_window_switch <= 4'hE;
    ppi_window_switch <= 4'hE;
    settle(4);
    bus(1'b0, 16'hE000, S_URAM);
    bus(1'b0, 16'h2000, S_TMEM);
    bus(1'b1, 16'hE2E2, S_PPI);
    @(posedge core_clk);
    ram_window_switch <= 4'h5;
    settle(4);
    reg_rd(REG_STATUS);
    check_reg({8'h00, rd}, 16'h000C);
    reg_wr(REG_STATUS, 8'h08);
    reg_rd(REG_STATUS);
    check_reg({8'h00, rd}, 16'h0004);
    reg_rd(REG_SWITCH);
    check_reg({8'h00, rd}, 16'h00E5);
    reg_rd(2'h3);
    check_reg({8'h00, rd}, 16'h0000);
    @(posedge core_clk);
    cpu_hold_ack <= 1'b1;
    settle(2);
    check_flag(hold_lamp, 1'b1);
    @(posedge core_clk);
    cpu_hold_ack <= 1'b0;
    settle(2);
    check_flag(hold_lamp, 1'b0);
    @(posedge core_clk);
    target_irq <= 4'hA;
    settle(5);
    check_reg({12'h000, cpu_irq}, 16'h000A);
    check_flag(cpu_trap, 1'b0);
    fetch(16'h0100);
    settle(5);
    check_flag(priority_interrupt_mask_lamp, 1'b0);
    check_flag(cpu_trap, 1'b1);
    reg_wr(REG_CTRL, 8'h01);
    settle(3);
    check_flag(priority_interrupt_mask_lamp, 1'b1);
    check_flag(cpu_trap, 1'b0);
    reg_wr(REG_CTRL, 8'h00);
    settle(3);
    check_flag(priority_interrupt_mask_lamp, 1'b0);
    fetch(16'hF900);
    settle(3);
    check_flag(priority_interrupt_mask_lamp, 1'b1);
    @(posedge core_clk);
    substitute_memory_key <= 1'b1;
    wait_lamp(1'b1);
    @(posedge core_clk);
    substitute_memory_key <= 1'b0;
    check_flag(substitute_lamp, 1'b1);
    bus(1'b0, 16'h0000, S_URAM);
    bus(1'b0, 16'h0FFF, S_URAM);
    fetch(16'h0123);
    check_sel(sels, S_URAM);
    bus(1'b0, 16'h1000, S_TMEM);
    bus(1'b0, 16'hF800, S_MROM);
    reg_wr(REG_CTRL, 8'h02);
    wait_lamp(1'b0);
    check_flag(substitute_lamp, 1'b0);
    bus(1'b0, 16'h0000, S_TMEM);
    bus(1'b0, 16'h5000, S_URAM);
    @(posedge core_clk);
    substitute_memory_key <= 1'b1;
    wait_lamp(1'b1);
    @(posedge core_clk);
    substitute_memory_key <= 1'b0;
    reset <= 1'b1;
    settle(3);
    @(posedge core_clk);
    reset <= 1'b0;
    settle(2);
    check_flag(substitute_lamp, 1'b0);
    report_and_stop();
  end
endmodule
